/* pkg/dcce_defines.vh */
// Constants for the DMA checksum engine: register map, field positions, reset values.
// Assumes inclusion by bare name from the core files.
`ifndef DCCE_DEFINES_VH
`define DCCE_DEFINES_VH
`define DCCE_AW 4
`define DCCE_ADDR_CTRL 4'h0
`define DCCE_ADDR_DATA 4'h4
`define DCCE_ADDR_TAPS 4'h8
`define DCCE_CTRL_RST 32'h00000000
`define DCCE_DATA_RST 32'h00000000
`define DCCE_TAPS_RST 32'h00000000
`define DCCE_CTRL_MASK 32'h39001FE7
`define DCCE_BYTE_ORDER_SELECT_HI 29
`define DCCE_BYTE_ORDER_SELECT_LO 28
`define DCCE_WBO_BIT 27
`define DCCE_BIT_ORDER_SELECT_BIT 24
`define DCCE_POLY_LENGTH_MINUS_ONE_HI 12
`define DCCE_POLY_LENGTH_MINUS_ONE_LO 8
`define DCCE_EN_BIT 7
`define DCCE_APP_BIT 6
`define DCCE_TYP_BIT 5
`define DCCE_CH_HI 2
`define DCCE_CH_LO 0
`define DCCE_BO_NONE 2'h0
`define DCCE_BO_WORD 2'h1
`define DCCE_BO_HALF 2'h2
`define DCCE_BO_HBYTE 2'h3
`define DCCE_BITS_PER_WORD 6'h20
`endif

/* core/dcce_reorder.v */
// Byte reordering of one 32-bit data word by a 2-bit order code.
// Assumes a purely combinational use in the same clock domain.
`include "dcce_defines.vh"
module dcce_reorder (
    input wire [1:0] order,
    input wire [31:0] din,
    output reg [31:0] dout
);
    always @* begin
        case (order)
            `DCCE_BO_NONE: dout = din;
            `DCCE_BO_WORD: dout = {din[7:0], din[15:8], din[23:16], din[31:24]};
            `DCCE_BO_HALF: dout = {din[15:0], din[31:16]};
            `DCCE_BO_HBYTE: dout = {din[23:16], din[31:24], din[7:0], din[15:8]};
            default: dout = din;
        endcase
    end
endmodule

/* core/dcce_engine.v */
// DMA checksum engine: LFSR CRC or IP header checksum on one selected channel.
// Assumes a channel engine on core_clk offering words with valid/ready and a block-done pulse.
//
// Functional notes
// - Byte order field reorders words before the checksum: none, word, half swap, half byte.
// - Write reorder bit sends reordered data to the destination, else unaltered.
// - IP mode: bit order set processes data reflected, clear most significant first.
// - LFSR mode: bit order set shifts least significant bit first, else MSB first.
// - Length field holds polynomial length minus one; ignored in IP mode.
// - Enable bit routes the chosen channel through the engine; otherwise bypass.
// - Append mode cannot be set while write reordering is on; no unaligned transfers.
// - Append: data feeds checksum only; on block end checksum written to destination start.
// - Append clear: data goes through checksum and on to destination, honouring reorder.
// - Type bit selects IP header checksum when set, LFSR CRC when clear.
// - Channel select field attaches the engine to channel 0 to 7.
// - Writing the data register seeds the generator.
// - Reading data returns current value, bits above length zero in LFSR mode.
// - IP mode: only low 16 bits carry the checksum, upper half reads zero.
// - IP mode: seed written and value read are in ones-complement form.
// - Unimplemented control bits read zero and ignore writes.
// - Tap mask bit set feeds XOR into that stage, clear shifts straight; unused in IP.
`include "dcce_defines.vh"
module dcce_engine (
    input wire core_clk,
    input wire resetn,
    input wire [`DCCE_AW-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire [2:0] src_channel,
    input wire src_valid,
    input wire [31:0] src_data,
    output wire src_ready,
    input wire src_block_done,
    output wire dst_valid,
    output reg [31:0] dst_data,
    input wire dst_ready,
    output wire dst_is_result,
    output wire [2:0] route_channel,
    output wire route_active
);
    localparam ST_IDLE = 2'h0;
    localparam ST_CRC = 2'h1;
    localparam ST_OUT = 2'h2;
    localparam ST_APP = 2'h3;

    reg [31:0] ctrl_r;
    reg [31:0] ctrl_nxt;
    reg [31:0] taps_r;
    reg [31:0] acc_r;
    reg [31:0] acc_nxt;
    reg [31:0] word_r;
    reg [5:0] bitcnt_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [31:0] read_val;
    reg done_pend_r;
    reg [31:0] dst_data_nxt;
    reg [31:0] rdata_nxt;

    wire [1:0] byte_order_select = ctrl_r[`DCCE_BYTE_ORDER_SELECT_HI:`DCCE_BYTE_ORDER_SELECT_LO];
    wire write_reorder_enable = ctrl_r[`DCCE_WBO_BIT];
    wire bit_order_select = ctrl_r[`DCCE_BIT_ORDER_SELECT_BIT];
    wire [4:0] poly_length_minus_one = ctrl_r[`DCCE_POLY_LENGTH_MINUS_ONE_HI:`DCCE_POLY_LENGTH_MINUS_ONE_LO];
    wire checksum_enable = ctrl_r[`DCCE_EN_BIT];
    wire append_mode = ctrl_r[`DCCE_APP_BIT];
    wire algorithm_type = ctrl_r[`DCCE_TYP_BIT];
    wire [2:0] checksum_channel_select = ctrl_r[`DCCE_CH_HI:`DCCE_CH_LO];

    wire [31:0] reordered;
    wire [31:0] len_mask;
    wire sel_hit;
    wire take;
    wire [31:0] reflected;
    wire wr_ctrl;
    wire wr_taps;
    wire wr_data;

    // Ones-complement 16-bit add with end-around carry
    function [15:0] oc_add;
        input [15:0] a;
        input [15:0] b;
        reg [16:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            oc_add = s[15:0] + {15'h0000, s[16]};
        end
    endfunction

    // Bit reversal within each 16-bit half
    function [31:0] half_reflect;
        input [31:0] v;
        integer i;
        begin
            half_reflect = 32'h00000000;
            for (i = 0; i < 16; i = i + 1) begin
                half_reflect[i] = v[15 - i];
                half_reflect[16 + i] = v[31 - i];
            end
        end
    endfunction

    // Sum of both halves of a word into the running 16-bit checksum
    function [15:0] ip_fold;
        input [15:0] sum;
        input [31:0] w;
        begin
            ip_fold = oc_add(oc_add(sum, w[31:16]), w[15:0]);
        end
    endfunction

    // One LFSR shift, feedback from the top stage of the configured length
    function [31:0] lfsr_step;
        input [31:0] cur;
        input [31:0] taps;
        input [31:0] mask;
        input [4:0] top;
        input din;
        begin
            if (cur[top] ^ din) begin
                lfsr_step = ((cur << 1) ^ taps) & mask;
            end else begin
                lfsr_step = (cur << 1) & mask;
            end
        end
    endfunction

    dcce_reorder i_dcce_reorder (
        .order(byte_order_select),
        .din(src_data),
        .dout(reordered)
    );

    // Mask of bits up to the configured length
    assign len_mask = {32{1'b1}} >> (5'h1F - poly_length_minus_one);
    assign sel_hit = checksum_enable && (src_channel == checksum_channel_select);
    assign route_active = sel_hit;
    assign route_channel = checksum_channel_select;
    assign src_ready = (state_r == ST_IDLE) && (!sel_hit || append_mode || dst_ready);
    assign take = src_valid && src_ready;
    assign reflected = half_reflect(reordered);
    assign wr_ctrl = reg_wr && (reg_addr == `DCCE_ADDR_CTRL);
    assign wr_taps = reg_wr && (reg_addr == `DCCE_ADDR_TAPS);
    assign wr_data = reg_wr && (reg_addr == `DCCE_ADDR_DATA);
    assign dst_valid = (state_r == ST_OUT) || (state_r == ST_APP);
    assign dst_is_result = (state_r == ST_APP);

    // Control write, reserved bits dropped and append blocked by reordering
    always @* begin
        ctrl_nxt = reg_wdata & `DCCE_CTRL_MASK;
        if (ctrl_nxt[`DCCE_WBO_BIT]) begin
            ctrl_nxt[`DCCE_APP_BIT] = 1'b0;
        end
    end

    // LFSR step or IP accumulate
    always @* begin
        acc_nxt = acc_r;
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take && sel_hit) begin
                    if (algorithm_type) begin
                        if (bit_order_select) begin
                            acc_nxt[15:0] = ip_fold(acc_r[15:0], reflected);
                        end else begin
                            acc_nxt[15:0] = ip_fold(acc_r[15:0], reordered);
                        end
                        acc_nxt[31:16] = 16'h0000;
                        state_nxt = append_mode ? ST_IDLE : ST_OUT;
                    end else begin
                        state_nxt = ST_CRC;
                    end
                end else if (take) begin
                    state_nxt = ST_OUT;
                end else if (done_pend_r && append_mode && sel_hit) begin
                    state_nxt = ST_APP;
                end
            end
            ST_CRC: begin
                acc_nxt = lfsr_step(acc_r, taps_r, len_mask, poly_length_minus_one,
                    bit_order_select ? word_r[0] : word_r[31]);
                if (bitcnt_r == `DCCE_BITS_PER_WORD - 6'h01) begin
                    state_nxt = append_mode ? ST_IDLE : ST_OUT;
                end
            end
            ST_OUT: begin
                if (dst_ready) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_APP: begin
                if (dst_ready) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Read view of the checksum
    always @* begin
        if (algorithm_type) begin
            read_val = {16'h0000, ~acc_r[15:0]};
        end else begin
            read_val = acc_r & len_mask;
        end
    end

    // Destination word: source data, reordered data or the appended result
    always @* begin
        dst_data_nxt = dst_data;
        if (take) begin
            if (!sel_hit || !write_reorder_enable) begin
                dst_data_nxt = src_data;
            end else begin
                dst_data_nxt = reordered;
            end
        end else if (state_nxt == ST_APP && state_r == ST_IDLE) begin
            dst_data_nxt = read_val;
        end
    end

    // Read data stands only in the cycle after the strobe
    always @* begin
        rdata_nxt = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                `DCCE_ADDR_CTRL: rdata_nxt = ctrl_r;
                `DCCE_ADDR_DATA: rdata_nxt = read_val;
                `DCCE_ADDR_TAPS: rdata_nxt = taps_r;
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Control register
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= `DCCE_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Tap mask register
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            taps_r <= `DCCE_TAPS_RST;
        end else if (wr_taps) begin
            taps_r <= reg_wdata;
        end
    end

    // Sequencer state
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Checksum, a seed write beats the engine step of the same cycle
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acc_r <= `DCCE_DATA_RST;
        end else if (wr_data) begin
            if (algorithm_type) begin
                acc_r <= {16'h0000, ~reg_wdata[15:0]};
            end else begin
                acc_r <= reg_wdata;
            end
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // Word being shifted and its bit count
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            word_r <= 32'h00000000;
            bitcnt_r <= 6'h00;
        end else if (take) begin
            word_r <= reordered;
            bitcnt_r <= 6'h00;
        end else if (state_r == ST_CRC) begin
            word_r <= bit_order_select ? {1'b0, word_r[31:1]} : {word_r[30:0], 1'b0};
            bitcnt_r <= bitcnt_r + 6'h01;
        end
    end

    // Block end pending until the result is sent, set beats clear
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            done_pend_r <= 1'b0;
        end else if (src_block_done && sel_hit && append_mode) begin
            done_pend_r <= 1'b1;
        end else if (state_r == ST_APP && dst_ready) begin
            done_pend_r <= 1'b0;
        end
    end

    // Registered data outputs
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dst_data <= 32'h00000000;
            reg_rdata <= 32'h00000000;
        end else begin
            dst_data <= dst_data_nxt;
            reg_rdata <= rdata_nxt;
        end
    end
endmodule

/* tb/dcce_engine_monitor.sv */
// Checker for the DMA checksum engine, watching its ports only.
// Assumes it is bound into every dcce_engine instance.
`include "dcce_defines.vh"
module dcce_engine_monitor (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [`DCCE_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [2:0] src_channel,
    input wire logic src_valid,
    input wire logic [31:0] src_data,
    input wire logic src_ready,
    input wire logic src_block_done,
    input wire logic dst_valid,
    input wire logic [31:0] dst_data,
    input wire logic dst_ready,
    input wire logic dst_is_result,
    input wire logic [2:0] route_channel,
    input wire logic route_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] ctl_r;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) ctl_r <= 32'h0;
        else if (reg_wr && reg_addr == 4'h0) ctl_r <= reg_wdata;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_ctrl_reserved_zero: assert property (reg_rd && reg_addr == 4'h0 |=> (reg_rdata & ~32'h39001FE7) == 32'h0)
        else $error("reserved control bits read nonzero");
    a_append_lock_out: assert property (reg_rd && reg_addr == 4'h0 && ctl_r[27] |=> !reg_rdata[6])
        else $error("append bit set beside write reorder");
    a_ip_upper_zero: assert property (reg_rd && reg_addr == 4'h4 && ctl_r[5] |=> reg_rdata[31:16] == 16'h0)
        else $error("upper half of header sum nonzero");
    a_lfsr_len_mask: assert property (reg_rd && reg_addr == 4'h4 && !ctl_r[5]
        |=> (reg_rdata >> ({1'b0, ctl_r[12:8]} + 6'h1)) == 32'h0)
        else $error("result bits above length nonzero");
    a_channel_field: assert property (route_channel == ctl_r[2:0])
        else $error("route channel differs from select field");
    a_route_match: assert property (route_active == (ctl_r[7] && src_channel == ctl_r[2:0]))
        else $error("route active wrong");
    a_lfsr_busy_hold: assert property (src_valid && src_ready && route_active && !ctl_r[5] |=> !src_ready [*8])
        else $error("word taken during shifting");
    a_bypass_data: assert property (src_valid && src_ready && !route_active && (!dst_valid || dst_ready)
        |=> dst_valid && dst_data == $past(src_data))
        else $error("bypassed word altered");
    a_result_valid: assert property (dst_is_result |-> dst_valid && ctl_r[6] && !ctl_r[27])
        else $error("result flag outside append mode");
    a_dst_hold: assert property (dst_valid && !dst_ready |=> dst_valid && $stable(dst_data) && $stable(dst_is_result))
        else $error("destination word dropped before accept");
endmodule
bind dcce_engine dcce_engine_monitor i_dcce_engine_monitor (.core_clk(core_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_channel(src_channel), .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
    .src_block_done(src_block_done), .dst_valid(dst_valid), .dst_data(dst_data), .dst_ready(dst_ready),
    .dst_is_result(dst_is_result), .route_channel(route_channel), .route_active(route_active));

/* tb/dcce_src_model.sv */
// Channel transfer engine model: offers words, ends blocks, sinks destination writes.
// Assumes the bench calls its tasks just after a rising edge of core_clk.
module dcce_src_model (
    input wire logic core_clk,
    input wire logic src_ready,
    input wire logic dst_valid,
    input wire logic [31:0] dst_data,
    input wire logic dst_is_result,
    input wire logic stall_en,
    output logic [2:0] src_channel,
    output logic src_valid,
    output logic [31:0] src_data,
    output logic src_block_done,
    output logic dst_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] dst_seen = 32'h0;
    logic res_seen = 1'b0;
    int dst_cnt = 0;
    initial begin
        src_channel = 3'h0;
        src_valid = 1'b0;
        src_data = 32'h0;
        src_block_done = 1'b0;
    end
    always @(posedge core_clk) begin
        dst_ready <= stall_en ? 1'($urandom_range(1)) : 1'b1;
        if (dst_valid && dst_ready) begin
            dst_seen <= dst_data;
            res_seen <= dst_is_result;
            dst_cnt <= dst_cnt + 1;
        end
    end
    // Whole aligned words only
    task automatic send(input logic [2:0] ch, input logic [31:0] d);
        @(posedge core_clk);
        src_channel <= ch;
        src_data <= d;
        src_valid <= 1'b1;
        @(posedge core_clk);
        while (!src_ready) @(posedge core_clk);
        src_valid <= 1'b0;
        src_data <= ~d;
    endtask
    // Block end only once the engine is idle
    task automatic block_end(input logic [2:0] ch);
        @(posedge core_clk);
        while (!src_ready) @(posedge core_clk);
        src_channel <= ch;
        src_block_done <= 1'b1;
        @(posedge core_clk);
        src_block_done <= 1'b0;
    endtask
endmodule

/* tb/test_dma_crc_checksum_engine.sv */
// Self-checking bench for the DMA checksum engine.
// Assumes the bound checker and the channel engine model.
module test_dma_crc_checksum_engine;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, stall_en = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, ctl, acc, tap, d, v;
    wire [31:0] reg_rdata, src_data, dst_data;
    wire [2:0] src_channel;
    wire src_valid, src_ready, src_block_done, dst_valid, dst_ready, dst_is_result;
    logic rt, ap;
    int mismatches = 0, checks = 0, n0;
    always #5 core_clk = ~core_clk;
    dcce_engine i_dcce_engine (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_channel(src_channel), .src_valid(src_valid),
        .src_data(src_data), .src_ready(src_ready), .src_block_done(src_block_done), .dst_valid(dst_valid),
        .dst_data(dst_data), .dst_ready(dst_ready), .dst_is_result(dst_is_result), .route_channel(), .route_active());
    dcce_src_model i_dcce_src_model (.core_clk(core_clk), .src_ready(src_ready), .dst_valid(dst_valid),
        .dst_data(dst_data), .dst_is_result(dst_is_result), .stall_en(stall_en), .src_channel(src_channel),
        .src_valid(src_valid), .src_data(src_data), .src_block_done(src_block_done), .dst_ready(dst_ready));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] x);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] x);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        x = reg_rdata;
        @(posedge core_clk);
    endtask
    task automatic wait_dst(input int n);
        for (int k = 0; k < 200 && i_dcce_src_model.dst_cnt == n; k++) @(posedge core_clk);
        if (i_dcce_src_model.dst_cnt == n) begin
            mismatches++;
            final_report();
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [31:0] reord(input logic [1:0] o, input logic [31:0] x);
        case (o)
            2'h1: return {x[7:0], x[15:8], x[23:16], x[31:24]};
            2'h2: return {x[15:0], x[31:16]};
            2'h3: return {x[23:16], x[31:24], x[7:0], x[15:8]};
            default: return x;
        endcase
    endfunction
    function automatic logic [31:0] lmask();
        logic [32:0] t = 33'h1 << ({1'b0, ctl[12:8]} + 6'h1);
        return t[31:0] - 32'h1;
    endfunction
    function automatic logic [15:0] oadd(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0, s[16]};
    endfunction
    function automatic logic [31:0] upd(input logic [31:0] a, input logic [31:0] x);
        logic [15:0] s = ~a[15:0];
        logic [31:0] r = reord(ctl[29:28], x);
        if (ctl[5]) begin
            if (ctl[24]) r = {<<{r}};
            if (ctl[24]) r = {r[15:0], r[31:16]};
            return {16'h0, ~oadd(oadd(s, r[31:16]), r[15:0])};
        end
        for (int i = 0; i < 32; i++) a = ((a << 1) ^ ((a[ctl[12:8]] ^ r[ctl[24] ? i : 31 - i]) ? tap : 32'h0)) & lmask();
        return a;
    endfunction
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        final_report();
    end
    initial begin
        void'($urandom(32'hC6050BCC));
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 4; i++) begin
            rd(4'(i * 4), d);
            chk("reset or unmapped read", d, 32'h0);
        end
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            ctl = $urandom & 32'h39001FE7;
            ctl[7] = (i % 8 != 7);
            ctl[5] = i[0];
            ctl[29:28] = i[2:1];
            ctl[24] = i[3];
            stall_en <= i[4];
            tap = $urandom;
            d = $urandom;
            rt = ctl[7] && (i % 8 != 6);
            ap = ctl[6] && !ctl[27];
            wr(4'h8, tap);
            wr(4'h0, ctl);
            wr(4'h4, d);
            acc = ctl[5] ? {16'h0, d[15:0]} : d & lmask();
            rd(4'h8, v);
            chk("tap mask", v, tap);
            rd(4'h0, v);
            chk("control", v, ctl & ~{25'h0, ctl[27], 6'h0});
            rd(4'h4, v);
            chk("seed", v, acc);
            repeat (ap ? 2 : 1) begin
                d = $urandom;
                n0 = i_dcce_src_model.dst_cnt;
                i_dcce_src_model.send(i % 8 == 6 ? ctl[2:0] + 3'h1 : ctl[2:0], d);
                if (rt) acc = upd(acc, d);
                if (!(rt && ap)) begin
                    wait_dst(n0);
                    chk("dst data", i_dcce_src_model.dst_seen, rt && ctl[27] ? reord(ctl[29:28], d) : d);
                end
            end
            if (rt && ap) begin
                n0 = i_dcce_src_model.dst_cnt;
                i_dcce_src_model.block_end(ctl[2:0]);
                wait_dst(n0);
                chk("appended result", i_dcce_src_model.dst_seen, acc);
                chk("result flag", {31'h0, i_dcce_src_model.res_seen}, 32'h1);
            end
            rd(4'h4, v);
            chk("checksum", v, acc);
            $display("test %0d done", i);
        end
        final_report();
    end
endmodule
